// ### asop_pkg.sv
// asop_pkg: constants and carriers for the sample output path.
// assumes one 20 MHz clock that doubles as the sample clock.
package asop_pkg;

  // word geometry
  localparam int CODE_W = 12;
  localparam int FRAC_W = 2;
  localparam int FINE_W = CODE_W + FRAC_W;
  localparam logic [CODE_W-1:0] CODE_MSB  = 12'h800;
  localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [CODE_W-1:0] CODE_FULL = 12'hFFF;

  // latency in sample clocks, last stage is the output latch
  localparam int PIPE_LAT = 10;
  localparam int PIPE_STG = PIPE_LAT - 1;

  // clock and rate
  localparam int SYS_CLK_HZ   = 20_000_000;
  localparam int MIN_RATE_SPS = 10_000_000;
  localparam int PROP_DLY_NS  = 50;
  localparam int PROP_DLY_CYC =
    (PROP_DLY_NS * (SYS_CLK_HZ / 1_000_000)) / 1000 < 1 ? 1 :
    (PROP_DLY_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;

  // threshold variation source
  localparam int LFSR_W = 16;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;
  localparam logic [FRAC_W-1:0] DITH_MID  = 2'h2;

  // strap synchroniser depth
  localparam int SYNC_W = 2;

  typedef struct packed {
    logic              valid;
    logic [CODE_W-1:0] raw;
  } asop_stage_t;

  typedef struct packed {
    logic              valid;
    logic [CODE_W-1:0] raw;
    logic [CODE_W-1:0] word;
  } asop_word_t;

endpackage

// ### asop_core.sv
// asop_core: quantiser, 9-stage pipeline, coding and output latches.
// assumes sys_clk_i is the sample clock; straps arrive as raw pins and
// the analog_input_i fine code is already on this clock.
`timescale 1ns/1ps

// Function
// - The coding is chosen by a static format strap pin, never a register.
// - Format strap high gives offset binary, mid-scale is only the MSB set.
// - Format strap low gives twos complement, mid-scale is all zeros.
// - An undriven format strap reads as low, so twos complement results.
// - Each output word is latched; with no receiver stall it is the sample taken 10 clocks earlier.
// - The output word updates at most once per clock, just after the rising edge.
// - Enhancement strap high lets code thresholds move from cycle to cycle.
// - Enhancement strap low keeps a static transfer function.
module asop_core (
  // clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  // strap pins
  input  wire logic                       number_format_select_i,
  input  wire logic                       number_format_select_drv_i,
  input  wire logic                       linearity_enhance_select_i,
  // converter front end
  input  wire logic [asop_pkg::FINE_W-1:0] analog_input_i,
  input  wire logic                       analog_valid_i,
  output logic                            analog_ready_o,
  // sample word out
  output logic [asop_pkg::CODE_W-1:0]     sample_word_o,
  output logic                            sample_valid_o,
  input  wire logic                       sample_ready_i
);

  localparam int CW = asop_pkg::CODE_W;
  localparam int NS = asop_pkg::PIPE_STG;

  // strap synchronisers
  logic [asop_pkg::SYNC_W-1:0] fmt_sync_r;
  logic [asop_pkg::SYNC_W-1:0] fmt_sync_nxt;
  logic [asop_pkg::SYNC_W-1:0] drv_sync_r;
  logic [asop_pkg::SYNC_W-1:0] drv_sync_nxt;
  logic [asop_pkg::SYNC_W-1:0] lin_sync_r;
  logic [asop_pkg::SYNC_W-1:0] lin_sync_nxt;
  logic                        fmt_eff;
  logic                        lin_eff;

  always_comb begin
    fmt_sync_nxt = {fmt_sync_r[0], number_format_select_i};
    drv_sync_nxt = {drv_sync_r[0], number_format_select_drv_i};
    lin_sync_nxt = {lin_sync_r[0], linearity_enhance_select_i};
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fmt_sync_r <= '0;
      drv_sync_r <= '0;
      lin_sync_r <= '0;
    end else begin
      fmt_sync_r <= fmt_sync_nxt;
      drv_sync_r <= drv_sync_nxt;
      lin_sync_r <= lin_sync_nxt;
    end
  end

  // static straps, no software path
  // a floating pin reads as pulled low
  assign fmt_eff = fmt_sync_r[1] & drv_sync_r[1];
  assign lin_eff = lin_sync_r[1];

  // threshold variation source
  logic [asop_pkg::LFSR_W-1:0] lfsr_r;
  logic [asop_pkg::LFSR_W-1:0] lfsr_nxt;
  logic [asop_pkg::FRAC_W-1:0] dith;

  always_comb begin
    lfsr_nxt = lfsr_r;
    if (lin_eff) begin
      lfsr_nxt = {1'b0, lfsr_r[asop_pkg::LFSR_W-1:1]};
      if (lfsr_r[0])
        lfsr_nxt = lfsr_nxt ^ asop_pkg::LFSR_TAPS;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      lfsr_r <= asop_pkg::LFSR_SEED;
    else
      lfsr_r <= lfsr_nxt;
  end

  // fixed mid offset rounds to nearest; moving offset shifts thresholds
  assign dith = lin_eff ? lfsr_r[asop_pkg::FRAC_W-1:0]
                        : asop_pkg::DITH_MID;

  // quantiser with saturation at full scale
  logic [asop_pkg::FINE_W:0] fine_sum;
  logic [CW-1:0]             code_q;

  always_comb begin
    fine_sum = {1'b0, analog_input_i}
             + {{(asop_pkg::FINE_W+1-asop_pkg::FRAC_W){1'b0}}, dith};
    if (fine_sum[asop_pkg::FINE_W])
      code_q = asop_pkg::CODE_FULL;
    else
      code_q = fine_sum[asop_pkg::FINE_W-1:asop_pkg::FRAC_W];
  end

  // pipeline; a full output buffer freezes it whole
  asop_pkg::asop_stage_t pipe_r   [NS];
  asop_pkg::asop_stage_t pipe_nxt [NS];
  asop_pkg::asop_stage_t pipe_in;
  asop_pkg::asop_stage_t pipe_out;
  logic                  stall;
  logic                  acc;

  assign pipe_in.valid = analog_valid_i;
  assign pipe_in.raw   = code_q;
  assign pipe_out      = pipe_r[NS-1];
  assign acc           = analog_valid_i & ~stall;

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_stage
      always_comb begin
        if (stall)
          pipe_nxt[g] = pipe_r[g];
        else if (g == 0)
          pipe_nxt[g] = pipe_in;
        else
          pipe_nxt[g] = pipe_r[(g == 0) ? 0 : g-1];
      end

      always_ff @(posedge sys_clk_i) begin
        if (rst_i)
          pipe_r[g] <= '0;
        else
          pipe_r[g] <= pipe_nxt[g];
      end
    end
  endgenerate

  // coding at the pipeline exit
  asop_pkg::asop_word_t conv;

  always_comb begin
    conv.valid = pipe_out.valid;
    conv.raw   = pipe_out.raw;
    if (fmt_eff)
      conv.word = pipe_out.raw;
    else
      conv.word = pipe_out.raw ^ asop_pkg::CODE_MSB;
  end

  // two-entry output latch; head drives the pins directly
  asop_pkg::asop_word_t head_r;
  asop_pkg::asop_word_t head_nxt;
  asop_pkg::asop_word_t tail_r;
  asop_pkg::asop_word_t tail_nxt;
  logic                 pop;
  logic                 push;

  assign pop   = head_r.valid & sample_ready_i;
  assign stall = pipe_out.valid & tail_r.valid & ~pop;
  assign push  = pipe_out.valid & ~stall;

  always_comb begin
    head_nxt = head_r;
    tail_nxt = tail_r;
    if (pop) begin
      if (tail_r.valid)
        head_nxt = tail_r;
      else if (push)
        head_nxt = conv;
      else
        head_nxt = '0;
      if (tail_r.valid && push)
        tail_nxt = conv;
      else
        tail_nxt = '0;
    end else if (push) begin
      if (!head_r.valid)
        head_nxt = conv;
      else
        tail_nxt = conv;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      head_r <= '0;
      tail_r <= '0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
    end
  end

  // latched outputs, one update per edge at most
  assign sample_word_o  = head_r.word;
  assign sample_valid_o = head_r.valid;
  // receiver stall reaches the front end instead of dropping words
  assign analog_ready_o = ~stall;

  // checks

  chk_strap_sync_path: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !$past(rst_i, 1) && !$past(rst_i, 2) |->
      fmt_eff == ($past(number_format_select_i, 2)
                & $past(number_format_select_drv_i, 2)))
    else $error("format strap not taken from the pin");

  chk_offset_binary_code: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    pipe_out.valid && fmt_eff |-> conv.word == pipe_out.raw)
    else $error("offset binary word differs from raw code");

  chk_twos_comp_code: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    pipe_out.valid && !fmt_eff |->
      conv.word[CW-1] == ~pipe_out.raw[CW-1]
      && conv.word[CW-2:0] == pipe_out.raw[CW-2:0])
    else $error("twos complement word wrong");

  chk_float_reads_low: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !drv_sync_r[1] |-> !fmt_eff)
    else $error("undriven format strap not read as low");

  chk_pipe_latency_fixed: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    acc ##1 (!stall)[*8] |=>
      pipe_out.valid && pipe_out.raw == $past(code_q, 9))
    else $error("sample not at pipeline exit after fixed latency");

  chk_output_update_edge: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    push && !head_r.valid |=>
      sample_valid_o && sample_word_o == $past(conv.word))
    else $error("output word not latched after the edge");

  chk_thresh_vary_on: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    lin_eff |=> lfsr_r != $past(lfsr_r))
    else $error("threshold source frozen while enabled");

  chk_static_transfer_off: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !lin_eff |-> dith == asop_pkg::DITH_MID
      && (fine_sum[asop_pkg::FINE_W]
          || code_q == fine_sum[asop_pkg::FINE_W-1:asop_pkg::FRAC_W]))
    else $error("transfer function not static when disabled");

  chk_stall_holds_word: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    stall |=> $stable(pipe_out) && $stable(head_r) && $stable(tail_r))
    else $error("word lost or changed under receiver stall");

  chk_head_holds_wait: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    sample_valid_o && !sample_ready_i |=>
      sample_valid_o && $stable(sample_word_o))
    else $error("presented word changed before it was taken");

endmodule

// ### asop_sink.sv
// asop_sink: capture logic standing behind the sample word outputs.
// assumes the sample clock is the only clock; bench sets stall and slow.
`timescale 1ns/1ps
module asop_sink (
  // clock
  input  wire logic                        sys_clk_i,
  // control from bench
  input  wire logic                        stall_i,
  input  wire logic                        slow_i,
  // sample word in
  input  wire logic [asop_pkg::CODE_W-1:0] sample_word_i,
  input  wire logic                        sample_valid_i,
  output logic                             sample_ready_o
);
  logic [asop_pkg::CODE_W-1:0] words[$];
  logic                        phase_r = 1'b0;
  initial sample_ready_o = 1'b0;
  // ready moves on the falling edge, clear of the capture edge
  always @(negedge sys_clk_i) begin
    phase_r        <= ~phase_r;
    sample_ready_o <= ~stall_i & (~slow_i | phase_r);
  end
  // registered on the sample clock; bench allows for latency
  always @(posedge sys_clk_i) begin
    if (sample_valid_i && sample_ready_o) words.push_back(sample_word_i);
  end
endmodule

// ### asop_core_test.sv
// asop_core_test: self-checking bench for the sample output path.
// assumes asop_pkg and asop_sink are compiled before it.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module asop_core_test;
  logic                         sys_clk_i = 1'b0;
  logic                         rst_i = 1'b1;
  logic                         number_format_select_i = 1'b0;
  logic                         number_format_select_drv_i = 1'b0;
  logic                         linearity_enhance_select_i = 1'b0;
  logic [asop_pkg::FINE_W-1:0]  analog_input_i = '0;
  logic                         analog_valid_i = 1'b0;
  logic                         analog_ready_o;
  logic [asop_pkg::CODE_W-1:0]  sample_word_o;
  logic                         sample_valid_o;
  logic                         sample_ready_i;
  logic                         stall = 1'b0;
  logic                         slow = 1'b0;
  int                           n_mismatch = 0;
  int                           num_checks = 0;
  int                           cyc = 0;
  int                           refused = 0;
  logic [13:0]                  fines [4] = '{14'h0000, 14'h1FFC, 14'h2000,
                                              14'h3FFF};
  // 50 ns period, 20 MSPS, twice the conversion floor
  always #25 sys_clk_i = ~sys_clk_i;
  asop_core dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .number_format_select_i(number_format_select_i),
    .number_format_select_drv_i(number_format_select_drv_i),
    .linearity_enhance_select_i(linearity_enhance_select_i),
    .analog_input_i(analog_input_i), .analog_valid_i(analog_valid_i),
    .analog_ready_o(analog_ready_o), .sample_word_o(sample_word_o),
    .sample_valid_o(sample_valid_o), .sample_ready_i(sample_ready_i));
  asop_sink snk (.sys_clk_i(sys_clk_i), .stall_i(stall), .slow_i(slow),
    .sample_word_i(sample_word_o), .sample_valid_i(sample_valid_o),
    .sample_ready_o(sample_ready_i));
  function automatic logic [11:0] exp_word(input logic [13:0] f, logic ob);
    logic [14:0] s;
    s = ({1'b0, f} + 15'h0002) >> 2;
    if (s > 15'h0FFF) s = 15'h0FFF;
    exp_word = ob ? s[11:0] : s[11:0] ^ asop_pkg::CODE_MSB;
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      summarize;
    end
  end
  task automatic straps(input logic f, d, e);
    @(negedge sys_clk_i);
    number_format_select_i = f;
    number_format_select_drv_i = d;
    linearity_enhance_select_i = e;
    repeat (4) @(negedge sys_clk_i);
    snk.words.delete();
  endtask
  task automatic send(input logic [13:0] f);
    logic r;
    @(negedge sys_clk_i);
    analog_input_i = f;
    analog_valid_i = 1'b1;
    forever begin
      #5 r = analog_ready_o;
      if (r) break;
      refused++;
      @(negedge sys_clk_i);
    end
    @(posedge sys_clk_i);
  endtask
  task automatic drain(input int n);
    int k;
    k = 0;
    @(negedge sys_clk_i);
    analog_valid_i = 1'b0;
    while (snk.words.size() < n && k < 200) begin
      @(negedge sys_clk_i);
      k++;
    end
    `CHK("count", n, snk.words.size())
  endtask
  task automatic code_run(input logic f, d);
    straps(f, d, 1'b0);
    foreach (fines[i]) send(fines[i]);
    drain(4);
  endtask
  task automatic t_offset;
    code_run(1'b1, 1'b1);
    foreach (snk.words[i])
      `CHK("obin", exp_word(fines[i], 1), snk.words[i])
    $display("test offset done");
  endtask
  task automatic t_twos;
    code_run(1'b0, 1'b1);
    foreach (snk.words[i])
      `CHK("twos", exp_word(fines[i], 0), snk.words[i])
    $display("test twos done");
  endtask
  task automatic t_float;
    code_run(1'b1, 1'b0);
    foreach (snk.words[i])
      `CHK("float", exp_word(fines[i], 0), snk.words[i])
    $display("test float done");
  endtask
  task automatic t_latency;
    int k;
    snk.words.delete();
    send(14'h1000);
    // the taking edge closes cycle 0; drop valid before a second take
    k = 1;
    @(negedge sys_clk_i);
    analog_valid_i = 1'b0;
    while (sample_valid_o !== 1'b1 && k < 20) begin
      @(negedge sys_clk_i);
      k++;
    end
    `CHK("latency", 10, k)
    `CHK("lat word", exp_word(14'h1000, 0), sample_word_o)
    drain(1);
    $display("test latency done");
  endtask
  task automatic t_stall;
    snk.words.delete();
    stall <= 1'b1;
    fork
      for (int i = 0; i < 16; i++) send(14'(i * 1000));
      begin
        repeat (40) @(negedge sys_clk_i);
        stall <= 1'b0;
        slow <= 1'b1;
      end
    join
    drain(16);
    slow <= 1'b0;
    `CHK("refused", 1'b1, refused > 0)
    foreach (snk.words[i])
      `CHK("order", exp_word(14'(i * 1000), 0), snk.words[i])
    $display("test stall done");
  endtask
  task automatic t_enh;
    logic [2:0] seen;
    straps(1'b1, 1'b1, 1'b0);
    repeat (8) send(14'h0192);
    drain(8);
    foreach (snk.words[i]) `CHK("static", 12'h065, snk.words[i])
    straps(1'b1, 1'b1, 1'b1);
    repeat (16) send(14'h0192);
    drain(16);
    seen = 3'h0;
    foreach (snk.words[i]) begin
      if (snk.words[i] === 12'h064) seen[1] = 1'b1;
      else if (snk.words[i] === 12'h065) seen[0] = 1'b1;
      else seen[2] = 1'b1;
    end
    `CHK("dynamic", 3'h3, seen)
    $display("test enhance done");
  endtask
  task automatic t_reset;
    straps(1'b1, 1'b1, 1'b0);
    repeat (3) send(14'h2000);
    @(negedge sys_clk_i);
    analog_valid_i = 1'b0;
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    `CHK("rst valid", 1'b0, sample_valid_o)
    `CHK("rst word", 12'h000, sample_word_o)
    `CHK("rst ready", 1'b1, analog_ready_o)
    rst_i = 1'b0;
    snk.words.delete();
    // straps resettle two edges after release
    repeat (2) @(negedge sys_clk_i);
    send(14'h2000);
    drain(1);
    `CHK("rst after", exp_word(14'h2000, 1), snk.words[0])
    $display("test reset done");
  endtask
  initial begin
    repeat (4) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_offset;
    t_twos;
    t_float;
    t_latency;
    t_stall;
    t_enh;
    t_reset;
    summarize;
  end
endmodule
